//--- logic/hk_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef HK_CTRL_DEFS_SVH
`define HK_CTRL_DEFS_SVH
`define ADDR_INTERRUPT_FLAGS     8'h02
`define ADDR_LINK_STATUS         8'h03
`define ADDR_MODE_CTRL           8'h40
`define ADDR_RESET_PULSE_CONFIG  8'h50
`define ADDR_INTERRUPT_CONFIG    8'h53
`define BIT_LINK_BROKEN          6
`define BIT_REMOTE_DONE          4
`define BIT_DATA_RECEIVED        3
`define BIT_IRQ_POLARITY         7
`define FLAG_MASK                8'h58
`define CFG_MASK                 8'hD8
`define PERIPH_RESET_OUT_MASK                8'h0F
`define CLEAR_ALL_VALUE          8'h7F
`define PERIPH_RESET_OUT_SEL_ENABLE          3'h4
`define BIT_TX_POWER_DOWN        6
`define BIT_RX_POWER_DOWN        7
`define BIT_FORCE_RECONFIG       4
`define RESET_VALUE_8            8'h00
`define PULSE_TIME_NS            285000
`define CLK_PERIOD_NS            40
`define PULSE_CYCLES             ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- logic/hk_ctrl_pkg.sv
// Types shared by the housekeeping controller
package hk_ctrl_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        PW_BOOT,
        PW_PULSE,
        PW_RUN,
        PW_DOWN
    } power_state_e;
endpackage

//--- logic/irq_reset_out_power_down_ctrl.sv
// Interrupt, peripheral reset pulse and power-down control of the device
// Functional notes
// [RQ1] Enabled event holds IRQ active until cleared
// [RQ2] Writing one clears that flag and interrupt
// [RQ3] Writing 0x7F clears every flag
// [RQ4] Flags at bits 6, 4, 3; rest zero
// [RQ5] Remote done set by send or transfer
// [RQ6] Data received means count bytes buffered
// [RQ7] Enables at config bits 6, 4, 3
// [RQ8] Config bit 7 selects IRQ polarity
// [RQ9] IRQ active iff flag and enable both set
// [RQ10] Reset pulse only in transmitter role
// [RQ11] Pulse after power-on and each reconfiguration; RECONFIG is only taken in PW_RUN, not in PW_PULSE or PW_DOWN
// [RQ12] Select 0 disables, 4 enables pulse
// [RQ13] Bit 0 selects pulse polarity
// [RQ14] Pulse lasts about 285 microseconds
// [RQ15] Power-down only by host command
// [RQ16] Transmitter mode bit 6 enters power-down
// [RQ17] Receiver mode bit 7 enters power-down
// [RQ18] Wake on falling edge of selected pin
// [RQ19] Registers kept through power-down
// [RQ20] Audio pins inputs until link established
// [RQ21] Host drives input audio pins, no floating
//
// Our own choice: strobed register access.
`include "hk_ctrl_defs.svh"
module irq_reset_out_power_down_ctrl #(
    parameter int PULSE_LEN = `PULSE_CYCLES
) (
    input  wire logic               CLK,
    input  wire logic               RST,
    input  wire logic               CE,
    input  wire logic [7:0]         ADDR,
    input  wire hk_ctrl_pkg::byte_t WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic [7:0]              RDATA,
    input  wire logic               TX_ROLE,
    input  wire logic               IF_SEL,
    input  wire logic               CHIP_SEL_N,
    input  wire logic               TWO_WIRE_DATA_PIN,
    input  wire logic               LINK_BROKEN_EV,
    input  wire logic               REMOTE_SEND_DONE,
    input  wire logic               LINK_CFG_DONE,
    input  wire logic               RX_DATA_READY,
    input  wire logic               LINK_UP,
    input  wire logic               RECONFIG,
    output logic                    IRQ,
    output logic                    PERIPH_RESET_OUT,
    output logic                    PERIPH_RESET_OE,
    output logic                    POWER_DOWN,
    output logic                    AUDIO_OUT_EN
);
    import hk_ctrl_pkg::*;

    byte_t        flags_reg;
    byte_t        cfg_reg;
    byte_t        periph_reset_out_reg;
    byte_t        mode_reg;
    logic         link_reg;
    logic [2:0]   wake_sync_reg;
    logic [31:0]  pulse_cnt_reg;
    power_state_e state_reg;
    byte_t        set_vec;
    byte_t        clr_vec;
    logic         wake_pin;
    logic         wake_fall;
    logic         pd_cmd;
    logic         pulse_on;
    logic         wake_lvl_reg;
    logic         irq_any;

    // Event sources map onto their flag positions
    always_comb begin
        set_vec = 8'h00;
        set_vec[`BIT_LINK_BROKEN]   = LINK_BROKEN_EV;
        set_vec[`BIT_REMOTE_DONE]   = REMOTE_SEND_DONE | LINK_CFG_DONE; // [RQ5]
        set_vec[`BIT_DATA_RECEIVED] = RX_DATA_READY; // [RQ6]
    end

    // 0x7F simply has every implemented bit set, so it clears all
    assign clr_vec = (WR && ADDR == `ADDR_INTERRUPT_FLAGS) ?
                     WDATA : 8'h00; // [RQ2] [RQ3]

    // Set wins over clear so no event is lost
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flags_reg <= `RESET_VALUE_8;
        end else if (CE) begin
            flags_reg <= ((flags_reg & ~clr_vec) | set_vec)
                         & `FLAG_MASK; // [RQ1] [RQ2] [RQ4]
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_reg  <= `RESET_VALUE_8;
            periph_reset_out_reg <= `RESET_VALUE_8;
            mode_reg <= `RESET_VALUE_8;
        end else if (CE && WR) begin
            if (ADDR == `ADDR_INTERRUPT_CONFIG) begin
                cfg_reg <= WDATA & `CFG_MASK; // [RQ7] [RQ8]
            end
            if (ADDR == `ADDR_RESET_PULSE_CONFIG) begin
                periph_reset_out_reg <= WDATA & `PERIPH_RESET_OUT_MASK; // [RQ12] [RQ13]
            end
            if (ADDR == `ADDR_MODE_CTRL) begin
                mode_reg <= WDATA;
            end
        end else if (CE && state_reg == PW_DOWN && wake_fall) begin
            // Only the power-down bits drop on wake; the rest is kept
            mode_reg[`BIT_TX_POWER_DOWN] <= 1'b0; // [RQ19]
            mode_reg[`BIT_RX_POWER_DOWN] <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            link_reg <= 1'b0;
        end else if (CE) begin
            link_reg <= LINK_UP;
        end
    end

    // IRQ level follows flags and enables, polarity from config
    assign IRQ = ((|(flags_reg & cfg_reg & `FLAG_MASK))
                  == cfg_reg[`BIT_IRQ_POLARITY]); // [RQ1] [RQ8] [RQ9]
    // Any pending source that is also enabled
    assign irq_any = |(flags_reg & cfg_reg & `FLAG_MASK);

    // Wake pin comes from outside: three stages, stages two and three agree
    assign wake_pin = IF_SEL ? TWO_WIRE_DATA_PIN : CHIP_SEL_N; // [RQ18]
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_sync_reg <= 3'h7;
        end else if (CE) begin
            wake_sync_reg <= {wake_sync_reg[1:0], wake_pin};
        end
    end
    // Level moves only once stages two and three agree, so a short
    // glitch on the pin cannot wake the device
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_lvl_reg <= 1'b1;
        end else if (CE && wake_sync_reg[1] == wake_sync_reg[2]) begin
            wake_lvl_reg <= wake_sync_reg[2];
        end
    end
    assign wake_fall = wake_lvl_reg && !wake_sync_reg[1]
                       && !wake_sync_reg[2]; // [RQ18]

    // Power-down only from a host register write
    assign pd_cmd = TX_ROLE ? mode_reg[`BIT_TX_POWER_DOWN]   // [RQ16]
                            : mode_reg[`BIT_RX_POWER_DOWN];  // [RQ17]

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg     <= PW_BOOT;
            pulse_cnt_reg <= 32'h0;
        end else if (CE) begin
            unique case (state_reg)
                PW_BOOT: begin
                    pulse_cnt_reg <= 32'h0;
                    state_reg     <= PW_PULSE; // [RQ11]
                end
                PW_PULSE: begin
                    if (pulse_cnt_reg >= 32'(PULSE_LEN - 1)) begin
                        state_reg <= PW_RUN; // [RQ14]
                    end else begin
                        pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
                    end
                end
                PW_RUN: begin
                    if (RECONFIG) begin
                        state_reg <= PW_BOOT; // [RQ11]
                    end else if (pd_cmd) begin
                        state_reg <= PW_DOWN; // [RQ15]
                    end
                end
                PW_DOWN: begin
                    if (wake_fall) begin
                        state_reg <= PW_RUN; // [RQ18] [RQ19]
                    end
                end
            endcase
        end
    end

    // Pulse only with transmitter role and select field equal to 4
    assign pulse_on = (state_reg == PW_PULSE) && TX_ROLE
                      && periph_reset_out_reg[3:1] == `PERIPH_RESET_OUT_SEL_ENABLE; // [RQ10] [RQ12]

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PERIPH_RESET_OUT <= 1'b0;
            PERIPH_RESET_OE  <= 1'b0;
        end else if (CE) begin
            PERIPH_RESET_OE  <= TX_ROLE
                && periph_reset_out_reg[3:1] == `PERIPH_RESET_OUT_SEL_ENABLE; // [RQ10] [RQ12]
            PERIPH_RESET_OUT <= pulse_on ~^ periph_reset_out_reg[0]; // [RQ13]
        end
    end

    assign POWER_DOWN   = (state_reg == PW_DOWN); // [RQ15]
    // Audio pins stay inputs until the link comes up; the host must
    // then drive them so they do not float in power-down
    assign AUDIO_OUT_EN = link_reg; // [RQ20] [RQ21]

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            RDATA <= 8'h00;
            if (RD) begin
                unique case (ADDR)
                    `ADDR_INTERRUPT_FLAGS:    RDATA <= flags_reg;
                    `ADDR_INTERRUPT_CONFIG:   RDATA <= cfg_reg;
                    `ADDR_RESET_PULSE_CONFIG: RDATA <= periph_reset_out_reg;
                    `ADDR_MODE_CTRL:          RDATA <= mode_reg;
                    `ADDR_LINK_STATUS:        RDATA <= {7'h00, link_reg};
                    default:                  RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Flags hold until cleared by the host
    a_flag_hold: assert property (@(posedge CLK) disable iff (RST) // [RQ1]
        CE && flags_reg[`BIT_LINK_BROKEN] && !clr_vec[`BIT_LINK_BROKEN]
        |=> flags_reg[`BIT_LINK_BROKEN])
        else $error("flag lost without clear");
    a_flag_clear: assert property (@(posedge CLK) disable iff (RST) // [RQ2]
        CE && clr_vec[`BIT_DATA_RECEIVED] && !RX_DATA_READY
        |=> !flags_reg[`BIT_DATA_RECEIVED])
        else $error("flag not cleared");
    a_clear_all: assert property (@(posedge CLK) disable iff (RST) // [RQ3]
        CE && clr_vec == `CLEAR_ALL_VALUE && set_vec == 8'h00
        |=> flags_reg == 8'h00)
        else $error("clear all failed");
    a_flag_reserved: assert property (@(posedge CLK) disable iff (RST) // [RQ4]
        (flags_reg & ~`FLAG_MASK) == 8'h00)
        else $error("reserved flag bit set");
    a_remote_done: assert property (@(posedge CLK) disable iff (RST) // [RQ5]
        CE && LINK_CFG_DONE |=> flags_reg[`BIT_REMOTE_DONE])
        else $error("remote done not set");
    a_irq_level: assert property (@(posedge CLK) disable iff (RST) // [RQ9]
        IRQ == (cfg_reg[7] ~^ (|(flags_reg & cfg_reg & `FLAG_MASK))))
        else $error("irq level wrong");
    a_pulse_role: assert property (@(posedge CLK) disable iff (RST) // [RQ10]
        CE && !TX_ROLE && $stable(TX_ROLE) |=> !PERIPH_RESET_OE)
        else $error("reset pin driven in receiver role");
    sequence s_pulse_start;
        CE && state_reg == PW_BOOT;
    endsequence
    a_pulse_begin: assert property (@(posedge CLK) disable iff (RST) // [RQ11]
        s_pulse_start |=> state_reg == PW_PULSE)
        else $error("pulse not started");
    a_pd_only_cmd: assert property (@(posedge CLK) disable iff (RST) // [RQ15]
        $rose(POWER_DOWN) |-> $past(pd_cmd))
        else $error("power-down without command");
    a_wake_up: assert property (@(posedge CLK) disable iff (RST) // [RQ18]
        CE && POWER_DOWN && wake_fall |=> !POWER_DOWN)
        else $error("no wake on falling edge");
    a_audio_in: assert property (@(posedge CLK) disable iff (RST) // [RQ20]
        $rose(AUDIO_OUT_EN) |-> $past(LINK_UP))
        else $error("audio pins driven before link");

    // Reserved bits of the interrupt and reset pulse config registers never hold a one
    a_cfg_reserved: assert property (@(posedge CLK) disable iff (RST) // [RQ7]
        (cfg_reg & ~`CFG_MASK) == 8'h00)
        else $error("reserved config bit set");
    a_periph_reset_out_rsvd: assert property (@(posedge CLK) disable iff (RST) // [RQ12]
        (periph_reset_out_reg & ~`PERIPH_RESET_OUT_MASK) == 8'h00)
        else $error("reserved reset config bit set");
    a_send_done: assert property (@(posedge CLK) disable iff (RST) // [RQ5]
        CE && REMOTE_SEND_DONE |=> flags_reg[`BIT_REMOTE_DONE])
        else $error("send done not flagged");
    a_clear_keep: assert property (@(posedge CLK) disable iff (RST) // [RQ3]
        CE && clr_vec == `CLEAR_ALL_VALUE
        |=> (flags_reg & ~$past(set_vec)) == 8'h00)
        else $error("flag kept after clear all");

    // Pin level checked per polarity, not by the pin's own expression
    a_irq_high: assert property (@(posedge CLK) disable iff (RST) // [RQ8]
        cfg_reg[`BIT_IRQ_POLARITY] && irq_any |-> IRQ)
        else $error("irq not high with high polarity");
    a_irq_low: assert property (@(posedge CLK) disable iff (RST) // [RQ8]
        !cfg_reg[`BIT_IRQ_POLARITY] && irq_any |-> !IRQ)
        else $error("irq not low with low polarity");
    a_irq_idle: assert property (@(posedge CLK) disable iff (RST) // [RQ9]
        !irq_any |-> IRQ != cfg_reg[`BIT_IRQ_POLARITY])
        else $error("irq active with nothing pending");

    // Pulse length counted in the state's own counter
    a_pulse_count: assert property (@(posedge CLK) disable iff (RST) // [RQ14]
        state_reg == PW_PULSE |-> pulse_cnt_reg < 32'(PULSE_LEN))
        else $error("pulse counter past its end");
    sequence s_pulse_last;
        CE && state_reg == PW_PULSE && pulse_cnt_reg == 32'(PULSE_LEN - 1);
    endsequence
    a_pulse_end: assert property (@(posedge CLK) disable iff (RST) // [RQ14]
        s_pulse_last |=> state_reg == PW_RUN)
        else $error("pulse did not end on time");
    a_reconf_boot: assert property (@(posedge CLK) disable iff (RST) // [RQ11]
        CE && state_reg == PW_RUN && RECONFIG |=> state_reg == PW_BOOT)
        else $error("reconfiguration did not restart");
    a_pulse_level: assert property (@(posedge CLK) disable iff (RST) // [RQ13]
        CE && pulse_on |=> PERIPH_RESET_OUT == $past(periph_reset_out_reg[0]))
        else $error("pulse level against polarity");
    a_pulse_idle: assert property (@(posedge CLK) disable iff (RST) // [RQ13]
        CE && !pulse_on |=> PERIPH_RESET_OUT != $past(periph_reset_out_reg[0]))
        else $error("idle reset level against polarity");
    a_periph_reset_out_off: assert property (@(posedge CLK) disable iff (RST) // [RQ12]
        CE && periph_reset_out_reg[3:1] != `PERIPH_RESET_OUT_SEL_ENABLE |=> !PERIPH_RESET_OE)
        else $error("reset pin driven while not selected");

    // Entry to power-down comes only from the mode bits, exit only from a wake edge
    sequence s_down_req;
        CE && state_reg == PW_RUN && !RECONFIG && pd_cmd;
    endsequence
    sequence s_rx_down_req;
        CE && state_reg == PW_RUN && !RECONFIG && !TX_ROLE
        && mode_reg[`BIT_RX_POWER_DOWN];
    endsequence
    a_pd_enter: assert property (@(posedge CLK) disable iff (RST) // [RQ16]
        s_down_req |=> POWER_DOWN)
        else $error("power-down command ignored");
    a_rx_down: assert property (@(posedge CLK) disable iff (RST) // [RQ17]
        s_rx_down_req |=> POWER_DOWN)
        else $error("receiver power-down command ignored");
    a_run_stays: assert property (@(posedge CLK) disable iff (RST) // [RQ15]
        CE && state_reg == PW_RUN && !pd_cmd |=> !POWER_DOWN)
        else $error("power-down entered without command");
    a_down_holds: assert property (@(posedge CLK) disable iff (RST) // [RQ18]
        CE && POWER_DOWN && !wake_fall |=> POWER_DOWN)
        else $error("left power-down without wake edge");
    sequence s_wake_quiet;
        CE && POWER_DOWN && wake_fall && !WR;
    endsequence
    a_wake_clear: assert property (@(posedge CLK) disable iff (RST) // [RQ19]
        s_wake_quiet |=> !mode_reg[`BIT_TX_POWER_DOWN]
        && !mode_reg[`BIT_RX_POWER_DOWN])
        else $error("power-down bits left set after wake");
    a_cfg_kept: assert property (@(posedge CLK) disable iff (RST) // [RQ19]
        CE && POWER_DOWN && !WR |=> $stable(cfg_reg) && $stable(periph_reset_out_reg))
        else $error("register changed in power-down");

    // Reads answer one cycle late and read zero otherwise
    a_rdata_zero: assert property (@(posedge CLK) disable iff (RST) // [RQ4]
        CE && !RD |=> RDATA == 8'h00)
        else $error("read data without read strobe");
    a_read_flags: assert property (@(posedge CLK) disable iff (RST) // [RQ4]
        CE && RD && ADDR == `ADDR_INTERRUPT_FLAGS
        |=> RDATA == $past(flags_reg))
        else $error("flag read returned wrong value");

    // A low clock enable freezes every state element
    a_freeze: assert property (@(posedge CLK) disable iff (RST) // [RQ19]
        !CE |=> $stable(state_reg) && $stable(flags_reg)
        && $stable(mode_reg) && $stable(RDATA))
        else $error("state moved with clock enable low");
    a_link_follow: assert property (@(posedge CLK) disable iff (RST) // [RQ20]
        CE |=> AUDIO_OUT_EN == $past(LINK_UP))
        else $error("audio drive not following link");

    // Hold, clear and set checked for each implemented flag bit
    localparam int FLAG_POS [3] = '{`BIT_LINK_BROKEN, `BIT_REMOTE_DONE,
                                    `BIT_DATA_RECEIVED};
    for (genvar g = 0; g < 3; g++) begin : g_flag_chk
        localparam int P = FLAG_POS[g];
        a_bit_keep: assert property (@(posedge CLK) disable iff (RST) // [RQ1]
            CE && flags_reg[P] && !clr_vec[P] |=> flags_reg[P])
            else $error("flag dropped without clear");
        a_bit_clr: assert property (@(posedge CLK) disable iff (RST) // [RQ2]
            CE && clr_vec[P] && !set_vec[P] |=> !flags_reg[P])
            else $error("flag survived its clear");
        a_bit_set: assert property (@(posedge CLK) disable iff (RST) // [RQ1]
            CE && set_vec[P] |=> flags_reg[P])
            else $error("flag event lost");
    end
endmodule

//--- verif/host_pins.sv
// Host-side model of the wake pins, pulled up while idle
module host_pins (
    input  wire logic clk,
    input  wire logic wake_spi,
    input  wire logic wake_tw,
    output logic      chip_sel_n,
    output logic      two_wire_data_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lines always driven, never floating
    // Only a host request pulls a line low
    initial begin
        chip_sel_n        = 1'b1;
        two_wire_data_pin = 1'b1;
        forever begin
            @(posedge clk);
            chip_sel_n        <= !wake_spi;
            two_wire_data_pin <= !wake_tw;
        end
    end
endmodule

//--- verif/irq_reset_out_power_down_ctrl_bench.sv
// Self-checking bench for interrupt, reset pulse and power-down control
`include "hk_ctrl_defs.svh"
module irq_reset_out_power_down_ctrl_bench import hk_ctrl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PLEN  = 8;
    localparam int LIMIT = 6000;
    logic        clk = 0, rst = 1, wr_s = 0, rd_s = 0, role = 0, sel = 0;
    logic        link_up = 0, reconfig = 0, wk_spi = 0, wk_tw = 0, ce = 1;
    logic [3:0]  evs = '0;
    logic [7:0]  addr = '0;
    byte_t       wdata = '0;
    logic [7:0]  rdata;
    logic        cs_n, tw_pin, irq, rso, oe, pd, aen;
    int          num_errors = 0, checks_done = 0, cyc = 0, flags = 0, cfg = 0;
    int unsigned rv;
    int          bitpos [4] = '{6, 4, 4, 3};
    byte_t       cfgs [4] = '{8'hD8, 8'h58, 8'h80, 8'hC0};
    irq_reset_out_power_down_ctrl #(.PULSE_LEN(PLEN)) i_irq_reset_out_power_down_ctrl (
        .CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .TX_ROLE(role), .IF_SEL(sel),
        .CHIP_SEL_N(cs_n), .TWO_WIRE_DATA_PIN(tw_pin),
        .LINK_BROKEN_EV(evs[0]), .REMOTE_SEND_DONE(evs[1]),
        .LINK_CFG_DONE(evs[2]), .RX_DATA_READY(evs[3]), .LINK_UP(link_up),
        .RECONFIG(reconfig), .IRQ(irq), .PERIPH_RESET_OUT(rso),
        .PERIPH_RESET_OE(oe), .POWER_DOWN(pd), .AUDIO_OUT_EN(aen));
    host_pins i_host_pins (.clk(clk), .wake_spi(wk_spi), .wake_tw(wk_tw),
        .chip_sel_n(cs_n), .two_wire_data_pin(tw_pin));
    initial forever #20 clk = ~clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask
    task automatic rc(string name, logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(name, rdata, exp);
    endtask
    task automatic irq_chk();
        logic act;
        @(negedge clk);
        act = |(flags & cfg & 8'h58);
        chk("irq", {7'h0, irq}, {7'h0, cfg[7] ? act : !act});
    endtask
    task automatic ev(int i);
        @(posedge clk);
        evs[i] <= 1'b1;
        @(posedge clk);
        evs[i] <= 1'b0;
        flags = flags | (1 << bitpos[i]);
    endtask
    task automatic clr(logic [7:0] d);
        wr(`ADDR_INTERRUPT_FLAGS, d);
        flags = flags & ~int'(d);
    endtask
    // Counts active cycles with the pin driven after a reconfiguration
    task automatic pulse(logic [7:0] periph_reset_out, logic r, int exp);
        int n;
        n = 0;
        @(posedge clk);
        role <= r;
        wr(`ADDR_RESET_PULSE_CONFIG, periph_reset_out);
        @(posedge clk);
        reconfig <= 1'b1;
        @(posedge clk);
        reconfig <= 1'b0;
        repeat (30) begin
            @(negedge clk);
            if (oe === 1'b1 && rso === periph_reset_out[0]) n++;
        end
        chk("pulse cycles", n[7:0], exp[7:0]);
    endtask
    task automatic wake(logic tw);
        @(posedge clk);
        wk_spi <= !tw;
        wk_tw  <= tw;
        repeat (4) @(posedge clk);
        wk_spi <= 1'b0;
        wk_tw  <= 1'b0;
        repeat (10) @(negedge clk);
    endtask
    task automatic pd_test(logic r, logic s, logic [7:0] mode);
        @(posedge clk);
        role <= r;
        sel  <= s;
        wr(`ADDR_MODE_CTRL, mode);
        repeat (2) @(negedge clk);
        chk("pd entered", {7'h0, pd}, 8'h01);
        rc("cfg kept", `ADDR_INTERRUPT_CONFIG, cfg[7:0]);
        wake(!s);
        chk("pd wrong pin", {7'h0, pd}, 8'h01);
        wake(s);
        chk("pd woken", {7'h0, pd}, 8'h00);
        rc("pd bits", `ADDR_MODE_CTRL, 8'h00);
        rc("cfg after", `ADDR_INTERRUPT_CONFIG, cfg[7:0]);
    endtask
    initial begin
        rv = $urandom(26922);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("irq idle", {7'h0, irq}, 8'h01);
        chk("pd idle", {7'h0, pd | oe | aen}, 8'h00);
        rc("flags rst", `ADDR_INTERRUPT_FLAGS, 8'h00);
        rc("unmapped", 8'h7E, 8'h00);
        repeat (4) begin
            rv = $urandom;
            wr(`ADDR_INTERRUPT_CONFIG, rv[7:0]);
            rc("cfg", `ADDR_INTERRUPT_CONFIG, rv[7:0] & 8'hD8);
            wr(`ADDR_RESET_PULSE_CONFIG, rv[15:8]);
            rc("periph_reset_out", `ADDR_RESET_PULSE_CONFIG, rv[15:8] & 8'h0F);
        end
        $display("test registers done");
        foreach (cfgs[k]) begin
            cfg = cfgs[k];
            wr(`ADDR_INTERRUPT_CONFIG, cfgs[k]);
            for (int i = 0; i < 4; i++) begin
                ev(i);
                irq_chk();
                rc("flags", `ADDR_INTERRUPT_FLAGS, flags[7:0]);
                clr(8'hA7);
                irq_chk();
                clr(8'(1 << bitpos[i]));
                irq_chk();
            end
            ev(0);
            ev(1);
            ev(3);
            clr(`CLEAR_ALL_VALUE);
            rc("flags all", `ADDR_INTERRUPT_FLAGS, 8'h00);
        end
        $display("test interrupts done");
        pulse(8'h09, 1'b1, PLEN);
        pulse(8'h08, 1'b1, PLEN);
        pulse(8'h09, 1'b0, 0);
        pulse(8'h03, 1'b1, 0);
        pulse(8'h01, 1'b1, 0);
        $display("test reset pulse done");
        pd_test(1'b1, 1'b0, 8'h40);
        pd_test(1'b0, 1'b1, 8'h80);
        $display("test power down done");
        @(posedge clk);
        ce     <= 1'b0;
        evs[0] <= 1'b1;
        repeat (2) @(posedge clk);
        evs[0] <= 1'b0;
        ce     <= 1'b1;
        rc("ce frozen", `ADDR_INTERRUPT_FLAGS, 8'h00);
        $display("test clock enable done");
        @(posedge clk);
        link_up <= 1'b1;
        repeat (3) @(negedge clk);
        chk("audio en", {7'h0, aen}, 8'h01);
        rc("link", `ADDR_LINK_STATUS, 8'h01);
        $display("test audio done");
        test_done();
    end
endmodule
